// [verilog/red_cfg.svh]
// Field positions, register offsets and control reset value for the remap entry low field decoder.
`ifndef RED_CFG_SVH
`define RED_CFG_SVH
`define RED_DEST_HI        63
`define RED_DEST_LO        32
`define RED_LEG_RSV_HI_MSB 63
`define RED_LEG_RSV_HI_LSB 48
`define RED_LEG_ID_MSB     47
`define RED_LEG_ID_LSB     40
`define RED_CLU_HI_MSB     47
`define RED_CLU_HI_LSB     44
`define RED_CLU_LO_MSB     43
`define RED_CLU_LO_LSB     40
`define RED_LEG_RSV_LO_MSB 39
`define RED_LEG_RSV_LO_LSB 32
`define RED_RSV_A_MSB      31
`define RED_RSV_A_LSB      24
`define RED_VEC_MSB        23
`define RED_VEC_LSB        16
`define RED_MODE_BIT       15
`define RED_RSV_B_MSB      14
`define RED_RSV_B_LSB      12
`define RED_SWA_MSB        11
`define RED_SWA_LSB        8
`define RED_PRESENT_BIT    0
`define RED_REG_CTRL       8'h00
`define RED_REG_STATUS     8'h04
`define RED_REG_DEST       8'h08
`define RED_REG_VECTOR     8'h0c
`define RED_REG_COUNT      8'h10
`define RED_CTRL_RST       32'h0000_0000
`endif

// [verilog/red_pkg.sv]
// Types shared by the remap entry low field decoder.
`default_nettype none
package red_pkg;
  typedef enum logic [2:0] {
    RED_AM_CLUSTER,
    RED_AM_FLAT,
    RED_AM_PHYSICAL,
    RED_AM_EXT_CLUSTER,
    RED_AM_EXT_PHYSICAL
  } red_addr_mode_t;
endpackage
`default_nettype wire

// [verilog/red_field_extract.sv]
// Combinational extraction of destination, vector and reserved-bit checks.
`timescale 1ns/1ps
`default_nettype none
`include "red_cfg.svh"
module red_field_extract (
  // Entry and mode.
  input  wire logic [127:0]              entry,
  input  wire red_pkg::red_addr_mode_t   mode,
  // Decoded fields.
  output logic      [31:0]               dest_id,
  output logic      [7:0]                vector,
  output logic                           post_mode,
  output logic                           rsv_fault
);
  logic legacy_rsv;
  logic fixed_rsv;

  always_comb
  begin
    dest_id    = 32'h0000_0000;
    legacy_rsv = 1'b0;
    unique case (mode)
      red_pkg::RED_AM_CLUSTER:
      begin
        dest_id[7:4] = entry[`RED_CLU_HI_MSB:`RED_CLU_HI_LSB];
        dest_id[3:0] = entry[`RED_CLU_LO_MSB:`RED_CLU_LO_LSB];
        legacy_rsv   = 1'b1;
      end
      red_pkg::RED_AM_FLAT:
      begin
        dest_id[7:0] = entry[`RED_LEG_ID_MSB:`RED_LEG_ID_LSB];
        legacy_rsv   = 1'b1;
      end
      red_pkg::RED_AM_PHYSICAL:
      begin
        dest_id[7:0] = entry[`RED_LEG_ID_MSB:`RED_LEG_ID_LSB];
        legacy_rsv   = 1'b1;
      end
      red_pkg::RED_AM_EXT_CLUSTER, red_pkg::RED_AM_EXT_PHYSICAL:
      begin
        dest_id = entry[`RED_DEST_HI:`RED_DEST_LO];
      end
      default:
      begin
        dest_id = entry[`RED_DEST_HI:`RED_DEST_LO];
      end
    endcase
  end

  // Legacy modes hold the unused destination bits reserved at zero.
  assign fixed_rsv = (|entry[`RED_RSV_A_MSB:`RED_RSV_A_LSB]) | (|entry[`RED_RSV_B_MSB:`RED_RSV_B_LSB]);
  assign rsv_fault = fixed_rsv | (legacy_rsv & ((|entry[`RED_LEG_RSV_HI_MSB:`RED_LEG_RSV_HI_LSB])
                                 | (|entry[`RED_LEG_RSV_LO_MSB:`RED_LEG_RSV_LO_LSB])));
  assign vector    = entry[`RED_VEC_MSB:`RED_VEC_LSB];
  assign post_mode = entry[`RED_MODE_BIT];
endmodule
`default_nettype wire

// [verilog/red_decoder.sv]
// Top level of the remap entry low field decoder with its register port.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "red_cfg.svh"
// Contract
// - Entry bits 63:32 carry the destination identifier whose layout follows the addressing mode.
// - The destination is evaluated only for entries whose present bit is set.
// - Legacy cluster mode puts destination 7:4 at bits 47:44 and 3:0 at 43:40, other bits reserved zero.
// - Legacy flat mode puts the 8-bit destination at bits 47:40, bits 63:48 and 39:32 reserved zero.
// - Extended cluster and physical modes use all of bits 63:32 as the 32-bit destination.
// - The 8-bit vector comes from bits 23:16 and is taken only for present entries.
// - Bit 15 set means a posted entry and clear means a remapped entry.
// - Bits 11:8 belong to software and never affect the hardware.
module red_decoder (
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  // Entry offered by the table walker.
  input  wire logic [127:0]  entry,
  input  wire logic          entry_valid,
  // Decoded result.
  output logic               result_valid,
  output logic      [31:0]   target_dest_id,
  output logic      [7:0]    vector,
  output logic               entry_post_mode,
  output logic               entry_fault,
  // Register port.
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata
);
  logic [31:0]              x_dest;
  logic [7:0]               x_vec;
  logic                     x_post;
  logic                     x_rsv;
  logic                     present;
  red_pkg::red_addr_mode_t  mode_q, mode_d;
  logic                     valid_q, valid_d;
  logic [31:0]              dest_q, dest_d;
  logic [7:0]               vec_q, vec_d;
  logic                     post_q, post_d;
  logic                     fault_q, fault_d;
  logic [15:0]              cnt_q, cnt_d;
  logic [31:0]              rdata_q, rdata_d;

  red_field_extract u_extract (
    .entry     (entry),
    .mode      (mode_q),
    .dest_id   (x_dest),
    .vector    (x_vec),
    .post_mode (x_post),
    .rsv_fault (x_rsv)
  );

  // Bits 11:8 are never routed anywhere, so software may keep private data there.
  assign present = entry[`RED_PRESENT_BIT];

  always_comb
  begin
    mode_d  = mode_q;
    valid_d = 1'b0;
    dest_d  = dest_q;
    vec_d   = vec_q;
    post_d  = post_q;
    fault_d = fault_q;
    cnt_d   = cnt_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr && reg_addr == `RED_REG_CTRL)
    begin
      // Unknown codes fall back to flat mode so the extractor never sees an illegal mode.
      if (reg_wdata[2:0] <= 3'h4)
        mode_d = red_pkg::red_addr_mode_t'(reg_wdata[2:0]);
      else
        mode_d = red_pkg::RED_AM_FLAT;
    end
    if (entry_valid && present)
    begin
      valid_d = 1'b1;
      dest_d  = x_dest;
      vec_d   = x_vec;
      post_d  = x_post;
      fault_d = x_rsv;
      cnt_d   = cnt_q + 16'h0001;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `RED_REG_CTRL:   rdata_d = {29'h0000_0000, mode_q};
        `RED_REG_STATUS: rdata_d = {30'h0000_0000, fault_q, post_q};
        `RED_REG_DEST:   rdata_d = dest_q;
        `RED_REG_VECTOR: rdata_d = {24'h00_0000, vec_q};
        `RED_REG_COUNT:  rdata_d = {16'h0000, cnt_q};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode_q  <= red_pkg::RED_AM_CLUSTER;
      valid_q <= 1'b0;
      dest_q  <= 32'h0000_0000;
      vec_q   <= 8'h00;
      post_q  <= 1'b0;
      fault_q <= 1'b0;
      cnt_q   <= 16'h0000;
      rdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      mode_q  <= mode_d;
      valid_q <= valid_d;
      dest_q  <= dest_d;
      vec_q   <= vec_d;
      post_q  <= post_d;
      fault_q <= fault_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  assign result_valid    = valid_q;
  assign target_dest_id  = dest_q;
  assign vector          = vec_q;
  assign entry_post_mode = post_q;
  assign entry_fault     = fault_q;
  assign reg_rdata       = rdata_q;
endmodule
`default_nettype wire

// [bench/red_dec_assertions.sv]
// Checker for the decoded outputs of the remap entry decoder.
`timescale 1ns/1ps
`default_nettype none
module red_dec_assertions (
  // Watched ports.
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire logic         clk_en,
  input wire logic [127:0] entry,
  input wire logic         entry_valid,
  input wire logic         result_valid,
  input wire logic [31:0]  target_dest_id,
  input wire logic [7:0]   vector,
  input wire logic         entry_post_mode,
  input wire logic         entry_fault
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic tk  = clk_en && entry_valid && entry[0];
  wire logic rsv = |entry[31:24] || |entry[14:12];
  wire logic cln = !rsv && entry[63:48] == 16'h0000 && entry[39:32] == 8'h00;
  a_take_answer: assert property (tk |=> result_valid) else $error("taken entry gave no result");
  a_no_absent: assert property (result_valid |-> $past(tk)) else $error("result without taken entry");
  a_vector_field: assert property (result_valid |-> vector == $past(entry[23:16])) else $error("vector");
  a_post_bit: assert property (result_valid |-> entry_post_mode == $past(entry[15])) else $error("mode");
  a_dest_layout: assert property (result_valid |-> target_dest_id == $past(entry[63:32]) ||
    target_dest_id == {24'h0, $past(entry[47:40])}) else $error("destination layout");
  a_fault_rsv: assert property (result_valid && $past(rsv) |-> entry_fault) else $error("missed fault");
  a_swa_ignored: assert property (result_valid && $past(cln) |-> !entry_fault) else $error("false fault");
  a_hold_data: assert property (!result_valid |-> $stable(vector) && $stable(target_dest_id))
    else $error("outputs moved");
  cover property (tk);
  cover property (result_valid && entry_fault);
  cover property (result_valid && entry_post_mode);
endmodule
bind red_decoder red_dec_assertions u_chk (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .entry(entry),
  .entry_valid(entry_valid), .result_valid(result_valid), .target_dest_id(target_dest_id), .vector(vector),
  .entry_post_mode(entry_post_mode), .entry_fault(entry_fault));
`default_nettype wire

// [bench/red_entry_model.sv]
// Table entry as software lays it out in memory.
`timescale 1ns/1ps
`default_nettype none
module red_entry_model (
  // Fields chosen by software.
  input  wire logic        ext,
  input  wire logic [31:0] dest,
  input  wire logic [7:0]  vec,
  input  wire logic        post,
  input  wire logic [3:0]  swa,
  input  wire logic        bad,
  input  wire logic        present,
  // Stored entry.
  output logic     [127:0] entry
);
  // The upper half stays zero because source validation lies outside this block.
  assign entry = {64'h0, ext ? dest : {16'h0, dest[7:0], 8'h0},
    bad ? 8'h01 : 8'h00, vec, post, 3'h0, swa, 7'h0, present};
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the remap entry decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         sys_clk = 0, reset = 1, clk_en = 1, entry_valid = 0, reg_wr = 0, reg_rd = 0;
  logic         ext = 0, xm = 0, post = 0, bad = 0, pres = 0, result_valid, entry_post_mode, entry_fault;
  logic [31:0]  dest = 0, reg_wdata = 0, reg_rdata, tdest;
  logic [7:0]   vec = 0, reg_addr = 0, vector;
  logic [3:0]   swa = 0;
  logic [127:0] entry;
  int           failures = 0, n_checks = 0;
  red_entry_model mdl (.ext(ext), .dest(dest), .vec(vec), .post(post), .swa(swa), .bad(bad), .present(pres),
    .entry(entry));
  red_decoder uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .entry(entry), .entry_valid(entry_valid),
    .result_valid(result_valid), .target_dest_id(tdest), .vector(vector), .entry_post_mode(entry_post_mode),
    .entry_fault(entry_fault), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  initial
    forever #2.5 sys_clk = ~sys_clk;
  task automatic test_done;
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Software bits change on every entry so that any leak into the outputs shows.
  task automatic snd(input logic p, input logic c, input logic [31:0] d, input logic [7:0] v, input logic b);
    @(posedge sys_clk);
    pres <= p;
    clk_en <= c;
    dest <= d;
    vec <= v;
    post <= ~post;
    bad <= b;
    swa <= swa + 4'h5;
    entry_valid <= 1'b1;
    @(posedge sys_clk);
    entry_valid <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk(result_valid, p & c);
    if (p & c)
    begin
      chk(tdest, xm ? (ext ? d : {16'h0, d[7:0], 8'h0})
                    : {24'h0, ext ? d[15:8] : d[7:0]});
      chk(vector, v);
      chk(entry_post_mode, post);
      chk(entry_fault, b | (~xm & ext & ((|d[31:16]) | (|d[7:0]))));
    end
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      wr(8'h00, 32'(m));
      ext <= m > 2;
      xm <= m > 2;
      snd(1'b1, 1'b1, 32'h9a5c_3e71 ^ 32'(m), 8'h21 + 8'(m), 1'b0);
    end
    snd(1'b1, 1'b1, 32'h0000_00ff, 8'hff, 1'b1);
    snd(1'b0, 1'b1, 32'h1, 8'h1, 1'b0);
    snd(1'b1, 1'b0, 32'h2, 8'h2, 1'b0);
    rd(8'h10, 32'h6);
    rd(8'h04, {30'h0, 2'h2});
    rd(8'h08, 32'hff);
    rd(8'h0c, 32'hff);
    wr(8'h00, 32'h5);
    rd(8'h00, 32'h1);
    // A full-width entry seen in a legacy mode trips the reserved-bit check only when bits outside 47:40 are set.
    @(posedge sys_clk);
    ext <= 1'b1;
    xm <= 1'b0;
    snd(1'b1, 1'b1, 32'h0001_ab00, 8'h5a, 1'b0);
    snd(1'b1, 1'b1, 32'h0000_cd01, 8'h5b, 1'b0);
    snd(1'b1, 1'b1, 32'h0000_ef00, 8'h5c, 1'b0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    test_done;
  end
  initial
  begin
    #100000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
